// ### hw/cdsl_cfg.svh
// Purpose: Constants for the column data shift and latch stage
// Assumes: Included by bare name from the shift and latch module and the testbench
// Notes: Definitions only
`ifndef CDSL_CFG_SVH
`define CDSL_CFG_SVH

// Column count and the half split point of the two-group layout
`define CDSL_NUM_OUT 192
`define CDSL_HALF_OUT 96

// Cells taken per shift in the wide and narrow layouts
`define CDSL_WIDE_STEP 6
`define CDSL_NARROW_STEP 3

// Shifts that fill every cell once
`define CDSL_WIDE_SHIFTS 7'h20
`define CDSL_NARROW_SHIFTS 7'h40

// Reset values
`define CDSL_COLS_RESET 192'h0
`define CDSL_COUNT_RESET 7'h00

`endif

// ### hw/cdsl_pkg.sv
// Purpose: Types shared by the column data shift and latch stage
// Assumes: Layout select pins are static while a line loads
// Notes: Constants live in cdsl_cfg.svh
`default_nettype none
package cdsl_pkg;

  // Layouts chosen by the two bus-select pins
  typedef enum logic [1:0] {
    CDSL_SIX_BY_32,
    CDSL_THREE_BY_64,
    CDSL_DIFFERENTIAL,
    CDSL_SPLIT_GROUPS
  } cdsl_mode_t;

endpackage

`default_nettype wire

// ### hw/cdsl_edge_if.sv
// Purpose: Event carrier between the pin edge detector and the shift core
// Assumes: One mclk domain
// Notes: Pulses last one mclk cycle
`timescale 1ns/1ps
`default_nettype none

interface cdsl_edge_if;
  logic diffMode;
  logic shiftPulse;
  logic strobeFall;

  modport det (input diffMode, output shiftPulse, output strobeFall);
  modport core (output diffMode, input shiftPulse, input strobeFall);
endinterface

`default_nettype wire

// ### hw/cdsl_edge_detect.sv
// Purpose: Turns shift clock and strobe levels into one-cycle events
// Assumes: Pins are synchronous to mclk, so one stage of history suffices
// Notes: Differential mode uses both edges of the clock pair
`timescale 1ns/1ps
`default_nettype none

module cdsl_edge_detect (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic shift_clock_primary,
  input wire logic shift_clock_secondary,
  input wire logic latch_strobe_n,
  cdsl_edge_if.det edges
);
  import cdsl_pkg::*;

  logic clkLevel;
  logic clkPrev_reg;
  logic strobePrev_reg;

  // A pair carries one level: high only when the true leg leads
  assign clkLevel = edges.diffMode ? (shift_clock_primary & ~shift_clock_secondary)
                                   : shift_clock_primary;

  // Previous levels for edge detection; idle high strobe avoids a false fall
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clkPrev_reg <= 1'b0;
      strobePrev_reg <= 1'b1;
    end else begin
      clkPrev_reg <= clkLevel;
      strobePrev_reg <= latch_strobe_n;
    end
  end

  // Rising edge only, or both edges in differential mode
  assign edges.shiftPulse = edges.diffMode ? (clkLevel != clkPrev_reg)
                                           : (clkLevel & ~clkPrev_reg);
  // Strobe is active low, so the event is its fall
  assign edges.strobeFall = strobePrev_reg & ~latch_strobe_n;

  diff_both_edges_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (edges.diffMode && $past(edges.diffMode)
      && $fell(shift_clock_primary & ~shift_clock_secondary)) |-> edges.shiftPulse)
    else $error("Differential falling clock edge did not shift");

  single_rise_only_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!edges.diffMode && $past(!edges.diffMode) && $fell(shift_clock_primary))
      |-> !edges.shiftPulse)
    else $error("Falling clock edge shifted in single-ended mode");

endmodule

`default_nettype wire

// ### hw/cdsl_shift_latch.sv
// Purpose: Column data shift registers and output latch of a 192-column driver
// Assumes: Pins synchronous to mclk; select and direction pins static per line
// Notes: Outputs lag the latch by one cycle through the blanking stage
//
// How it works
// - Two select pins pick six, three, differential or split two-group layout
// - Three-chain layout uses inputs one to three; others use all six
// - Direction pin chooses low-to-high or high-to-low loading order
// - Each shift clock rise samples the inputs and advances every chain
// - Strobe fall copies the whole shift register into the output latch
// - While the strobe is high the latch holds, whatever shifting goes on
// - Three-bit bus: first bit on input one ends at column 1, or at 190 in reverse
// - Three-bit: clock k lands at 3k-2..3k, reverse first at 190..192
// - Both selects low: six-bit bus, six bits per clock, 32 clocks
// - Six-bit: clock k input j lands at 6(k-1)+j, reverse first at 187..192
// - Split: inputs four to six land 96 higher; reverse first 94-96, 190-192
// - Differential: pairs carry one signal, sampled on both clock edges
// - Strobe and blanking are active low
`timescale 1ns/1ps
`default_nettype none
`include "cdsl_cfg.svh"

module cdsl_shift_latch (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic bus_select_a,
  input wire logic bus_select_b,
  input wire logic load_reverse,
  input wire logic shift_clock_primary,
  input wire logic shift_clock_secondary,
  input wire logic latch_strobe_n,
  input wire logic blanking_n,
  input wire logic data_in_1,
  input wire logic data_in_2,
  input wire logic data_in_3,
  input wire logic data_in_4,
  input wire logic data_in_5,
  input wire logic data_in_6,
  output logic [`CDSL_NUM_OUT-1:0] column_out,
  output cdsl_pkg::cdsl_mode_t active_mode,
  output logic line_loaded
);
  import cdsl_pkg::*;

  localparam int N = `CDSL_NUM_OUT;
  localparam int H = `CDSL_HALF_OUT;
  localparam int W6 = `CDSL_WIDE_STEP;
  localparam int W3 = `CDSL_NARROW_STEP;

  cdsl_edge_if edges ();

  cdsl_mode_t mode;
  logic [W6-1:0] dIn;
  logic [N-1:0] shiftReg_reg;
  logic [N-1:0] shiftReg_next;
  logic [N-1:0] latch_reg;
  logic [N-1:0] columnOut_reg;
  logic [6:0] shiftCount_reg;

  // Pin pair to layout
  function automatic cdsl_mode_t decodeMode(input logic selA, input logic selB);
    case ({selA, selB})
      2'b00: decodeMode = CDSL_SIX_BY_32;
      2'b10: decodeMode = CDSL_THREE_BY_64;
      2'b01: decodeMode = CDSL_DIFFERENTIAL;
      default: decodeMode = CDSL_SPLIT_GROUPS;
    endcase
  endfunction

  // Shifts needed to refill every cell in a layout
  function automatic logic [6:0] fullCount(input cdsl_mode_t m);
    case (m)
      CDSL_SIX_BY_32, CDSL_SPLIT_GROUPS: fullCount = `CDSL_WIDE_SHIFTS;
      default: fullCount = `CDSL_NARROW_SHIFTS;
    endcase
  endfunction

  // One shift step; normal order enters at the top so early bits end low
  function automatic logic [N-1:0] shiftStep(input logic [N-1:0] sr, input cdsl_mode_t m,
                                              input logic rev, input logic [W6-1:0] d);
    case (m)
      CDSL_SIX_BY_32: begin
        if (rev) begin
          shiftStep = {sr[N-W6-1:0], d};
        end else begin
          shiftStep = {d, sr[N-1:W6]};
        end
      end
      CDSL_SPLIT_GROUPS: begin
        if (rev) begin
          shiftStep = {sr[N-W3-1:H], d[5:3], sr[H-W3-1:0], d[2:0]};
        end else begin
          shiftStep = {d[5:3], sr[N-1:H+W3], d[2:0], sr[H-1:W3]};
        end
      end
      default: begin
        if (rev) begin
          shiftStep = {sr[N-W3-1:0], d[2:0]};
        end else begin
          shiftStep = {d[2:0], sr[N-1:W3]};
        end
      end
    endcase
  endfunction

  assign mode = decodeMode(bus_select_a, bus_select_b);
  assign active_mode = mode;
  assign edges.diffMode = (mode == CDSL_DIFFERENTIAL);

  // Input word; the three-chain layout ignores the upper pins, differential folds each pin pair into one bit
  always_comb begin
    dIn = {data_in_6, data_in_5, data_in_4, data_in_3, data_in_2, data_in_1};
    if (mode == CDSL_THREE_BY_64) begin
      dIn = {3'h0, data_in_3, data_in_2, data_in_1};
    end else if (mode == CDSL_DIFFERENTIAL) begin
      // True leg high and complement low reads as one
      dIn = {3'h0, data_in_5 & ~data_in_6, data_in_3 & ~data_in_4,
             data_in_1 & ~data_in_2};
    end
  end

  cdsl_edge_detect edgeDet (
    .mclk(mclk),
    .rst_n(rst_n),
    .shift_clock_primary(shift_clock_primary),
    .shift_clock_secondary(shift_clock_secondary),
    .latch_strobe_n(latch_strobe_n),
    .edges(edges.det)
  );

  assign shiftReg_next = shiftStep(shiftReg_reg, mode, load_reverse, dIn);

  // Shift chains advance only on a shift clock event
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shiftReg_reg <= `CDSL_COLS_RESET;
    end else if (edges.shiftPulse) begin
      shiftReg_reg <= shiftReg_next;
    end
  end

  // Latch copies the pre-shift contents, so a same-cycle shift is not mixed in
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= `CDSL_COLS_RESET;
    end else if (edges.strobeFall) begin
      latch_reg <= shiftReg_reg;
    end
  end

  // Blanking forces all columns low without disturbing the latch
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      columnOut_reg <= `CDSL_COLS_RESET;
    end else begin
      columnOut_reg <= blanking_n ? latch_reg : `CDSL_COLS_RESET;
    end
  end
  assign column_out = columnOut_reg;

  // Shifts since the last strobe, so a short load can be spotted
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shiftCount_reg <= `CDSL_COUNT_RESET;
    end else if (edges.strobeFall) begin
      shiftCount_reg <= {6'h00, edges.shiftPulse};
    end else if (edges.shiftPulse && shiftCount_reg != 7'h7f) begin
      shiftCount_reg <= shiftCount_reg + 7'h01;
    end
  end
  assign line_loaded = (shiftCount_reg >= fullCount(mode));

  latch_load_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    edges.strobeFall |=> (latch_reg == $past(shiftReg_reg)))
    else $error("Latch did not take the shift register on strobe fall");

  latch_hold_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!edges.strobeFall && edges.shiftPulse) |=> $stable(latch_reg))
    else $error("Latch changed while strobe stayed high");

  shift_idle_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !edges.shiftPulse |=> $stable(shiftReg_reg))
    else $error("Shift register moved without a clock edge");

  six_normal_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (edges.shiftPulse && mode == CDSL_SIX_BY_32 && !load_reverse)
      |=> (shiftReg_reg[N-1:N-W6] == $past(dIn)) && (shiftReg_reg[N-W6-1:0] ==
           $past(shiftReg_reg[N-1:W6])))
    else $error("Six-bit normal shift misplaced data");

  three_reverse_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (edges.shiftPulse && mode == CDSL_THREE_BY_64 && load_reverse)
      |=> (shiftReg_reg[N-1:W3] == $past(shiftReg_reg[N-W3-1:0]))
          && (shiftReg_reg[W3-1:0] == $past(dIn[W3-1:0])))
    else $error("Three-bit reverse shift misplaced data");

  split_halves_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (edges.shiftPulse && mode == CDSL_SPLIT_GROUPS && !load_reverse)
      |=> (shiftReg_reg[N-1:N-W3] == $past(dIn[5:3]))
          && (shiftReg_reg[H-1:H-W3] == $past(dIn[2:0])))
    else $error("Split layout halves loaded wrongly");

  narrow_pins_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (mode == CDSL_THREE_BY_64) |-> (dIn[5:3] == 3'h0))
    else $error("Upper data pins used in three-chain layout");

  blank_out_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!blanking_n ##1 !blanking_n) |-> (column_out == `CDSL_COLS_RESET))
    else $error("Columns not forced low while blanked");

  loaded_count_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    edges.strobeFall |=> (shiftCount_reg <= 7'h01) && !line_loaded)
    else $error("Shift count not restarted at strobe");

endmodule

`default_nettype wire

// ### testbench/cdsl_tcon_model.sv
// Purpose: Behavioural timing controller on the driver's data, clock and strobe pins
// Assumes: Pins change 1 ns after an mclk rise; layout pins set by the bench
// Notes: Released data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none

module cdsl_tcon_model (
  input wire logic mclk,
  output logic clkPri,
  output logic clkSec,
  output logic strobeN,
  output logic [5:0] dataOut
);
  // Idle: clock still and low, strobe inactive high
  initial begin
    clkPri = 1'h0;
    clkSec = 1'h1;
    strobeN = 1'h1;
    dataOut = 6'h00;
  end

  // One shift; data valid with the clock rise, then the clock drops; differential toggles the pair once
  task automatic shift(input logic diff, input logic [5:0] d);
    if (diff) begin
      // True and inverted legs per pair; every change of the pair is an edge
      dataOut = {~d[2], d[2], ~d[1], d[1], ~d[0], d[0]};
      clkPri = ~clkPri;
      clkSec = ~clkPri;
      @(posedge mclk) #1;
    end else begin
      dataOut = d;
      clkPri = 1'h1;
      clkSec = 1'h0;
      @(posedge mclk) #1;
      clkPri = 1'h0;
      clkSec = 1'h1;
      dataOut = ~d;
      @(posedge mclk) #1;
    end
  endtask

  // One-cycle active-low strobe with data lines released
  task automatic strobe();
    dataOut = ~dataOut;
    strobeN = 1'h0;
    @(posedge mclk) #1;
    strobeN = 1'h1;
    @(posedge mclk) #1;
  endtask
endmodule

`default_nettype wire

// ### testbench/cdsl_shift_latch_tb.sv
// Purpose: Self-checking bench for the column shift and latch stage
// Assumes: Inputs change 1 ns after mclk rises
// Notes: Expected columns come from a queue of the bits sent per line
`timescale 1ns/1ps
`default_nettype none
`include "cdsl_cfg.svh"

module cdsl_shift_latch_tb;
  import cdsl_pkg::*;
  logic mclk, rst_n, selA, selB, rev, blankN, clkPri, clkSec, strobeN, lineLoaded;
  logic [5:0] data;
  logic [`CDSL_NUM_OUT-1:0] columnOut, expCol;
  cdsl_mode_t activeMode;
  logic [5:0] lineQ[$];
  int failCount = 0;
  int checked = 0;
  int seed = 74;

  cdsl_tcon_model u_tcon (.mclk(mclk), .clkPri(clkPri), .clkSec(clkSec),
    .strobeN(strobeN), .dataOut(data));
  cdsl_shift_latch DUT (.mclk(mclk), .rst_n(rst_n), .bus_select_a(selA),
    .bus_select_b(selB), .load_reverse(rev), .shift_clock_primary(clkPri),
    .shift_clock_secondary(clkSec), .latch_strobe_n(strobeN), .blanking_n(blankN),
    .data_in_1(data[0]), .data_in_2(data[1]), .data_in_3(data[2]), .data_in_4(data[3]),
    .data_in_5(data[4]), .data_in_6(data[5]), .column_out(columnOut),
    .active_mode(activeMode), .line_loaded(lineLoaded));

  // 25 MHz system clock
  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [191:0] seen, input logic [191:0] exp);
    checked++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Column of each queued bit: mode 0 six, 1 three, 2 differential, 3 split
  function automatic logic [191:0] expLine(input int m, input logic r);
    logic [191:0] v;
    int jj, off, pos;
    v = 192'h0;
    for (int k = 1; k <= lineQ.size(); k++)
      for (int j = 1; j <= 6; j++) begin
        jj = (j > 3) ? j - 3 : j;
        off = (j > 3) ? 96 : 0;
        if (m == 0) pos = r ? 192 - 6 * k + j : 6 * (k - 1) + j;
        else if (m == 3) pos = off + (r ? 96 - 3 * k + jj : 3 * k - 3 + jj);
        else pos = (j > 3) ? 0 : (r ? 192 - 3 * k + j : 3 * k - 3 + j);
        if (pos > 0) v[pos-1] = lineQ[k-1][j-1];
      end
    return v;
  endfunction

  // Full line, strobe, compare; then shift more and see the latch hold
  task automatic runLine(input int m, input logic r);
    int n;
    logic [5:0] d;
    n = (m == 0 || m == 3) ? 32 : 64;
    selA = (m == 1 || m == 3);
    selB = (m == 2 || m == 3);
    rev = r;
    lineQ.delete();
    @(posedge mclk) #1;
    check("activeMode", 192'(activeMode), 192'(m));
    for (int k = 0; k < n; k++) begin
      d = 6'($random(seed));
      lineQ.push_back(d);
      u_tcon.shift(m == 2, d);
    end
    check("lineLoaded", 192'(lineLoaded), 192'h1);
    u_tcon.strobe();
    expCol = expLine(m, r);
    check("columnOut", columnOut, expCol);
    check("lineLoaded", 192'(lineLoaded), 192'h0);
    for (int k = 0; k < 5; k++)
      u_tcon.shift(m == 2, 6'($random(seed)));
    check("columnOut", columnOut, expCol);
    $display("Line mode %0d reverse %0d done", m, r);
  endtask

  // Watchdog well beyond the fewer than a thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge mclk);
    failCount++;
    finish_test();
  end

  initial begin
    rst_n = 1'h0;
    selA = 1'h0;
    selB = 1'h0;
    rev = 1'h0;
    blankN = 1'h1;
    repeat (20) @(posedge mclk);
    #1;
    check("columnOut", columnOut, 192'h0);
    rst_n = 1'h1;
    for (int m = 0; m < 4; m++)
      for (int r = 0; r < 2; r++)
        runLine(m, 1'(r));
    // Blanking forces zero without touching the latch
    blankN = 1'h0;
    repeat (2) @(posedge mclk);
    #1;
    check("blanked", columnOut, 192'h0);
    blankN = 1'h1;
    repeat (2) @(posedge mclk);
    #1;
    check("unblanked", columnOut, expCol);
    $display("Blanking test done");
    // Second reset in mid-run clears the outputs at once
    rst_n = 1'h0;
    #2;
    check("resetCols", columnOut, 192'h0);
    check("resetLoaded", 192'(lineLoaded), 192'h0);
    @(posedge mclk) #1;
    rst_n = 1'h1;
    runLine(3, 1'h1);
    finish_test();
  end
endmodule

`default_nettype wire
